// file: twu_pkg.sv
package twu_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [4:0] OFF_ADDR = 5'h00;
    localparam logic [4:0] OFF_CTRL = 5'h04;
    localparam logic [4:0] OFF_STAT = 5'h08;
    localparam logic [4:0] OFF_DATA = 5'h0C;
    localparam logic [4:0] OFF_IRQ  = 5'h10;
    localparam logic [4:0] OFF_MASK = 5'h14;

    // ==========================================================
    // Field positions
    localparam int CB_FLAG  = 7;
    localparam int CB_ACK   = 6;
    localparam int CB_START = 5;
    localparam int CB_STOP  = 4;
    localparam int CB_EN    = 2;
    localparam int AB_GC    = 0;
    localparam int IB_DONE  = 0;
    localparam int IB_WAKE  = 1;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_STAT = 8'hF8;
    localparam logic [1:0] RST_MASK = 2'h0;

    // ==========================================================
    // Bus constants and status codes
    localparam logic [6:0] GC_ADDR     = 7'h00;
    localparam logic [7:0] SC_OWN_ADDR = 8'h60;
    localparam logic [7:0] SC_ARB_OWN  = 8'h68;
    localparam logic [7:0] SC_GC_ADDR  = 8'h70;
    localparam logic [7:0] SC_ARB_GC   = 8'h78;
    localparam logic [7:0] SC_OWN_ACK  = 8'h80;
    localparam logic [7:0] SC_OWN_NACK = 8'h88;
    localparam logic [7:0] SC_GC_ACK   = 8'h90;
    localparam logic [7:0] SC_GC_NACK  = 8'h98;
    localparam logic [7:0] SC_STOP_RX  = 8'hA0;
    localparam logic [7:0] SC_ST_ADDR  = 8'hA8;
    localparam logic [2:0] BIT_LAST    = 3'h7;

endpackage : twu_pkg

// file: twu_line_if.sv
`timescale 1ns/1ps
`default_nettype none
interface twu_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport src  (output scl, sda, scl_rise, scl_fall, start, stop);
    modport sink (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : twu_line_if
`default_nettype wire

// file: twu_line_sync.sv
`timescale 1ns/1ps
`default_nettype none
module twu_line_sync (
    input  wire logic   ref_clk_in,
    input  wire logic   sys_rst_in,
    input  wire logic   scl_in,
    input  wire logic   sda_in,
    twu_line_if.src     lnk
);

    logic scl_s1_ff;
    logic scl_s2_ff;
    logic scl_d_ff;
    logic sda_s1_ff;
    logic sda_s2_ff;
    logic sda_d_ff;

    // ==========================================================
    // Two-stage synchronisers; idle bus lines are high
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff  <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff  <= 1'b1;
        end else begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff  <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff  <= sda_s2_ff;
        end
    end

    // ==========================================================
    // Edges and bus conditions, seen only past the second stage
    assign lnk.scl      = scl_s2_ff;
    assign lnk.sda      = sda_s2_ff;
    assign lnk.scl_rise = scl_s2_ff & ~scl_d_ff;
    assign lnk.scl_fall = ~scl_s2_ff & scl_d_ff;
    assign lnk.start    = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
    assign lnk.stop     = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;

endmodule : twu_line_sync
`default_nettype wire

// file: twu_slave_rx.sv
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module twu_slave_rx (
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        sleep_in,
    input  wire logic        arb_lost_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic             scl_out,
    output logic             scl_oe_out,
    output logic             sda_out,
    output logic             sda_oe_out,
    output logic             irq_out,
    output logic             wake_out,
    output logic             start_launch_out
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_DATA,
        S_DATA_ACK,
        S_IGNORE
    } twu_state_e;

    twu_line_if lnk ();

    twu_state_e  state_ff;
    logic [2:0]  cnt_ff;
    logic [7:0]  shift_ff;
    logic        ack_ff;
    logic        slot_ff;
    logic        gc_mode_ff;
    logic        st_mode_ff;
    logic        busy_ff;
    logic        ev_ff;
    logic [7:0]  ev_code_ff;
    logic [7:0]  own_addr_ff;
    logic        ack_en_ff;
    logic        start_req_ff;
    logic        stop_req_ff;
    logic        en_ff;
    logic        flag_ff;
    logic [7:0]  status_ff;
    logic [7:0]  rx_data_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic        start_pend_ff;
    logic        wr_go;
    logic        wr_ctrl;
    logic        clr_flag;
    logic        own_hit;
    logic        gc_hit;
    logic        byte_end;
    logic [31:0] nxt_rdata;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    twu_line_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .lnk        (lnk.src)
    );

    // Codes after which the unit has left the addressed state
    function automatic logic is_released(input logic [7:0] code);
        is_released = (code == twu_pkg::SC_OWN_NACK) ||
                      (code == twu_pkg::SC_GC_NACK)  ||
                      (code == twu_pkg::SC_STOP_RX);
    endfunction : is_released

    // ==========================================================
    // Avalon slave: one wait cycle, then the answer
    assign wr_go    = avs_write_in && !avs_waitrequest_out;
    assign wr_ctrl  = wr_go && (avs_address_in == twu_pkg::OFF_CTRL);
    // A clear only counts against a flag that is really up
    assign clr_flag = wr_ctrl && avs_writedata_in[twu_pkg::CB_FLAG]
                      && flag_ff && !ev_ff;

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_address_in)
            twu_pkg::OFF_ADDR: nxt_rdata[7:0] = own_addr_ff;
            twu_pkg::OFF_CTRL: nxt_rdata[7:0] = {flag_ff, ack_en_ff,
                start_req_ff, stop_req_ff, 1'b0, en_ff, 2'h0};
            twu_pkg::OFF_STAT: nxt_rdata[7:0] = status_ff;
            twu_pkg::OFF_DATA: nxt_rdata[7:0] = rx_data_ff;
            twu_pkg::OFF_IRQ:  nxt_rdata[1:0] = irq_stat_ff;
            twu_pkg::OFF_MASK: nxt_rdata[1:0] = irq_mask_ff;
            default:           nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out    <= nxt_rdata;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    AST_BUS_ANSWER: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus request not answered in one cycle");

    // ==========================================================
    // Software-written configuration
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            own_addr_ff  <= twu_pkg::RST_ADDR;
            ack_en_ff    <= twu_pkg::RST_CTRL[twu_pkg::CB_ACK];
            start_req_ff <= twu_pkg::RST_CTRL[twu_pkg::CB_START];
            stop_req_ff  <= twu_pkg::RST_CTRL[twu_pkg::CB_STOP];
            en_ff        <= twu_pkg::RST_CTRL[twu_pkg::CB_EN];
            irq_mask_ff  <= twu_pkg::RST_MASK;
        end else if (wr_go) begin
            if (avs_address_in == twu_pkg::OFF_ADDR) begin
                own_addr_ff <= avs_writedata_in[7:0];
            end
            if (wr_ctrl) begin
                ack_en_ff    <= avs_writedata_in[twu_pkg::CB_ACK];
                start_req_ff <= avs_writedata_in[twu_pkg::CB_START];
                stop_req_ff  <= avs_writedata_in[twu_pkg::CB_STOP];
                en_ff        <= avs_writedata_in[twu_pkg::CB_EN];
            end
            if (avs_address_in == twu_pkg::OFF_MASK) begin
                irq_mask_ff <= avs_writedata_in[1:0];
            end
        end
    end

    // ==========================================================
    // Address matching on the eighth bit of the address byte
    assign byte_end = lnk.scl_rise && (cnt_ff == twu_pkg::BIT_LAST);
    // Ack-enable low isolates the unit from both addresses
    assign own_hit  = ack_en_ff &&
                      (shift_ff[6:0] == own_addr_ff[7:1]);
    assign gc_hit   = ack_en_ff && own_addr_ff[twu_pkg::AB_GC] &&
                      (shift_ff[6:0] == twu_pkg::GC_ADDR);

    // ==========================================================
    // Bit engine, paced by edges of the bus clock
    always_ff @(posedge ref_clk_in) begin
        ev_ff <= 1'b0;
        if (sys_rst_in || !en_ff) begin
            state_ff   <= S_IDLE;
            cnt_ff     <= 3'h0;
            shift_ff   <= 8'h00;
            ack_ff     <= 1'b0;
            slot_ff    <= 1'b0;
            gc_mode_ff <= 1'b0;
            st_mode_ff <= 1'b0;
            busy_ff    <= 1'b0;
            ev_code_ff <= twu_pkg::RST_STAT;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            wake_out   <= 1'b0;
            rx_data_ff <= 8'h00;
        end else if (lnk.start || lnk.stop) begin
            if (state_ff == S_DATA || state_ff == S_DATA_ACK) begin
                ev_ff      <= 1'b1;
                ev_code_ff <= twu_pkg::SC_STOP_RX;
            end
            state_ff   <= lnk.start ? S_ADDR : S_IDLE;
            busy_ff    <= lnk.start;
            cnt_ff     <= 3'h0;
            slot_ff    <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            if (clr_flag) begin
                scl_oe_out <= 1'b0;
                wake_out   <= 1'b0;
            end
            if (lnk.scl_rise && (state_ff == S_ADDR || state_ff == S_DATA)) begin
                shift_ff <= {shift_ff[6:0], lnk.sda};
                cnt_ff   <= cnt_ff + 3'h1;
            end
            if (byte_end && state_ff == S_ADDR) begin
                if (own_hit || gc_hit) begin
                    state_ff   <= S_ADDR_ACK;
                    ack_ff     <= 1'b1;
                    gc_mode_ff <= gc_hit && !own_hit;
                    st_mode_ff <= lnk.sda;
                end else begin
                    state_ff <= S_IGNORE;
                end
            end
            if (byte_end && state_ff == S_DATA) begin
                state_ff <= S_DATA_ACK;
                // Sampled at byte end, so a late clear still takes effect
                ack_ff   <= ack_en_ff;
                // Only data bytes land here; the address byte never does
                rx_data_ff <= {shift_ff[6:0], lnk.sda};
            end
            if (lnk.scl_fall && !slot_ff &&
                (state_ff == S_ADDR_ACK || state_ff == S_DATA_ACK)) begin
                slot_ff    <= 1'b1;
                // Drive low for acknowledge; release gives the high nack
                sda_oe_out <= ack_ff;
            end
            if (lnk.scl_fall && slot_ff) begin
                slot_ff    <= 1'b0;
                sda_oe_out <= 1'b0;
                ev_ff      <= 1'b1;
                // Pull the clock before the master can release it
                scl_oe_out <= 1'b1;
                cnt_ff     <= 3'h0;
                if (state_ff == S_ADDR_ACK) begin
                    wake_out <= sleep_in;
                    if (st_mode_ff) begin
                        // No transmitter here: report and step aside
                        ev_code_ff <= twu_pkg::SC_ST_ADDR;
                        state_ff   <= S_IGNORE;
                    end else begin
                        state_ff <= S_DATA;
                        if (gc_mode_ff) begin
                            ev_code_ff <= arb_lost_in ? twu_pkg::SC_ARB_GC
                                                      : twu_pkg::SC_GC_ADDR;
                        end else begin
                            ev_code_ff <= arb_lost_in ? twu_pkg::SC_ARB_OWN
                                                      : twu_pkg::SC_OWN_ADDR;
                        end
                    end
                end else if (ack_ff) begin
                    state_ff   <= S_DATA;
                    ev_code_ff <= gc_mode_ff ? twu_pkg::SC_GC_ACK
                                             : twu_pkg::SC_OWN_ACK;
                end else begin
                    state_ff   <= S_IGNORE;
                    ev_code_ff <= gc_mode_ff ? twu_pkg::SC_GC_NACK
                                             : twu_pkg::SC_OWN_NACK;
                end
            end
        end
    end

    sequence seq_ack_open;
        lnk.scl_fall && !slot_ff &&
        (state_ff == S_ADDR_ACK || state_ff == S_DATA_ACK);
    endsequence

    sequence seq_ack_close;
        lnk.scl_fall && slot_ff && !lnk.start && !lnk.stop && en_ff;
    endsequence

    AST_OWN_MATCH: assert property (
        byte_end && state_ff == S_ADDR && en_ff && !lnk.start && !lnk.stop
        && ack_en_ff && shift_ff[6:0] == own_addr_ff[7:1]
        |=> state_ff == S_ADDR_ACK)
        else $error("own address not matched");

    AST_GC_IGNORED: assert property (
        byte_end && state_ff == S_ADDR && en_ff && !lnk.start && !lnk.stop
        && shift_ff[6:0] == twu_pkg::GC_ADDR && !own_addr_ff[twu_pkg::AB_GC]
        && own_addr_ff[7:1] != twu_pkg::GC_ADDR
        |=> state_ff == S_IGNORE)
        else $error("general call answered while disabled");

    AST_NO_ACK_WHEN_OFF: assert property (
        byte_end && state_ff == S_ADDR && en_ff && !lnk.start && !lnk.stop
        && !ack_en_ff |=> state_ff == S_IGNORE)
        else $error("address answered with ack-enable low");

    AST_DIRECTION: assert property (
        byte_end && state_ff == S_ADDR && en_ff && !lnk.start && !lnk.stop
        && (own_hit || gc_hit) |=> st_mode_ff == $past(lnk.sda))
        else $error("direction bit not recorded");

    AST_ACK_LEVEL: assert property (
        seq_ack_open and (en_ff && !lnk.start && !lnk.stop)
        |=> sda_oe_out == $past(ack_ff) ##1 (sda_oe_out == ack_ff || !slot_ff))
        else $error("acknowledge level wrong");

    AST_CODE_OWN: assert property (
        seq_ack_close and (state_ff == S_ADDR_ACK && !gc_mode_ff
        && !st_mode_ff && !arb_lost_in)
        |=> ##1 flag_ff && status_ff == twu_pkg::SC_OWN_ADDR)
        else $error("own address status wrong");

    AST_NACK_DROP: assert property (
        seq_ack_close and (state_ff == S_DATA_ACK && !ack_ff && !gc_mode_ff)
        |=> state_ff == S_IGNORE ##1 status_ff == twu_pkg::SC_OWN_NACK)
        else $error("nack byte did not release the unit");

    AST_STRETCH: assert property (
        flag_ff && scl_oe_out && !clr_flag && en_ff && !lnk.start && !lnk.stop
        |=> scl_oe_out)
        else $error("clock released before flag clear");

    AST_WAKE_HOLD: assert property (
        wake_out |-> scl_oe_out)
        else $error("wake without clock hold");

    // ==========================================================
    // Completion flag and status; a new event wins over a clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flag_ff   <= 1'b0;
            status_ff <= twu_pkg::RST_STAT;
        end else if (ev_ff) begin
            flag_ff   <= 1'b1;
            status_ff <= ev_code_ff;
        end else if (clr_flag) begin
            flag_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Start launch once the bus is free
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            start_pend_ff    <= 1'b0;
            start_launch_out <= 1'b0;
        end else begin
            start_launch_out <= 1'b0;
            if (clr_flag && avs_writedata_in[twu_pkg::CB_START]
                && is_released(status_ff)) begin
                start_pend_ff <= 1'b1;
            end else if (start_pend_ff && !busy_ff) begin
                start_pend_ff    <= 1'b0;
                start_launch_out <= 1'b1;
            end
        end
    end

    AST_START_LAUNCH: assert property (
        start_pend_ff && !busy_ff && !clr_flag |=> start_launch_out)
        else $error("start not launched on free bus");

    // ==========================================================
    // Interrupt: sticky events, write one to clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            irq_stat_ff <= 2'h0;
            irq_out     <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_go && avs_address_in == twu_pkg::OFF_IRQ
                    && avs_writedata_in[i]) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
            if (ev_ff) begin
                irq_stat_ff[twu_pkg::IB_DONE] <= 1'b1;
            end
            if (wake_out) begin
                irq_stat_ff[twu_pkg::IB_WAKE] <= 1'b1;
            end
            irq_out <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    AST_IRQ: assert property (
        |(irq_stat_ff & irq_mask_ff) |=> irq_out)
        else $error("masked-in event did not raise interrupt");

    // ==========================================================
    // Open-drain data levels: only ever pull low
    always_ff @(posedge ref_clk_in) begin
        scl_out <= 1'b0;
        sda_out <= 1'b0;
    end

endmodule : twu_slave_rx
`default_nettype wire

// file: twu_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Master transmitter: both lines idle released, clock still between frames
module twu_master_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_low_out,
    output logic      sda_low_out
);
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    // Honours stretching; a clock held for ever gives ok = 0
    task automatic rise(output logic ok);
        int n;
        scl_low_out = 1'b0;
        n = 0;
        while (scl_in !== 1'b1 && n < 5000) begin
            #40;
            n++;
        end
        ok = (n < 5000);
    endtask : rise
    // Data moves 40 ns after the fall so it never races the clock edge
    task automatic bit_out(input logic b, output logic seen);
        logic ok;
        #40;
        sda_low_out = ~b;
        #120;
        rise(ok);
        seen = ok ? sda_in : 1'bx;
        #160;
        scl_low_out = 1'b1;
    endtask : bit_out
    task automatic start_cond();
        sda_low_out = 1'b1;
        #160;
        scl_low_out = 1'b1;
    endtask : start_cond
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(d[i], s);
        bit_out(1'b1, ack);
    endtask : put_byte
    task automatic stop_cond();
        logic ok;
        #40;
        sda_low_out = 1'b1;
        #120;
        rise(ok);
        #160;
        sda_low_out = 1'b0;
    endtask : stop_cond
endmodule : twu_master_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, sleep_in = 1'b0, arb_lost_in = 1'b0;
    logic        avs_read_in = 1'b0, avs_write_in = 1'b0, launched = 1'b0;
    logic [4:0]  avs_address_in = 5'h00;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
    logic        avs_waitrequest_out, scl_oe_out, sda_oe_out, irq_out, wake_out;
    logic        start_launch_out, m_scl_low, m_sda_low, scl_line, sda_line;
    logic        scl_lvl, sda_lvl;
    int          miscompares = 0, num_checks = 0;
    logic [7:0]  st_tab [4] = '{twu_pkg::SC_OWN_ADDR, twu_pkg::SC_GC_ADDR,
                                twu_pkg::SC_ARB_OWN, twu_pkg::SC_ARB_GC};
    // ==========================================================
    // Open-drain wires with pull-ups
    assign scl_line = ~(m_scl_low | scl_oe_out);
    assign sda_line = ~(m_sda_low | sda_oe_out);
    always #20 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (start_launch_out === 1'b1) launched <= 1'b1;
    twu_slave_rx u_dut (.ref_clk_in, .sys_rst_in, .scl_in(scl_line), .sda_in(sda_line),
        .sleep_in, .arb_lost_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .scl_out(scl_lvl),
        .scl_oe_out, .sda_out(sda_lvl), .sda_oe_out, .irq_out, .wake_out, .start_launch_out);
    twu_master_model mst (.scl_in(scl_line), .sda_in(sda_line), .scl_low_out(m_scl_low),
        .sda_low_out(m_sda_low));
    // ==========================================================
    // Tasks
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge ref_clk_in);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= ~w;
        avs_writedata_in <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            print_verdict();
        end
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr
    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        check(q, e);
    endtask : rchk
    task automatic clr();
        wr(twu_pkg::OFF_CTRL, 8'hC4);
    endtask : clr
    task automatic wait_flag();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(twu_pkg::OFF_CTRL, 1'b0, 8'h00, q);
            n++;
        end while (q[twu_pkg::CB_FLAG] !== 1'b1 && n < 300);
        check(q[twu_pkg::CB_FLAG], 1'b1);
    endtask : wait_flag
    task automatic send(input logic [7:0] d, input logic exp_ack, input logic [7:0] st);
        logic ack;
        mst.put_byte(d, ack);
        check(ack, exp_ack);
        if (st != 8'h00) begin
            wait_flag();
            rchk(twu_pkg::OFF_STAT, st);
        end
    endtask : send
    task automatic end_frame();
        mst.stop_cond();
        wait_flag();
        rchk(twu_pkg::OFF_STAT, twu_pkg::SC_STOP_RX);
        clr();
    endtask : end_frame
    // ==========================================================
    // Sequence
    initial begin
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rchk(twu_pkg::OFF_STAT, twu_pkg::RST_STAT);
        rchk(5'h18, 32'h0);
        wr(twu_pkg::OFF_ADDR, 8'hAB);
        rchk(twu_pkg::OFF_ADDR, 8'hAB);
        wr(twu_pkg::OFF_MASK, 8'h01);
        wr(twu_pkg::OFF_CTRL, 8'h44);
        for (int i = 0; i < 4; i++) begin
            arb_lost_in <= i[1];
            mst.start_cond();
            send(i[0] ? 8'h00 : 8'hAA, 1'b0, st_tab[i]);
            check(scl_oe_out, 1'b1);
            check({scl_lvl, sda_lvl}, 2'h0);
            check(irq_out, 1'b1);
            wr(twu_pkg::OFF_IRQ, 8'h01);
            repeat (3) @(posedge ref_clk_in);
            check(irq_out, 1'b0);
            clr();
            send(8'h3C + 8'(i), 1'b0, i[0] ? twu_pkg::SC_GC_ACK : twu_pkg::SC_OWN_ACK);
            rchk(twu_pkg::OFF_DATA, 8'h3C + 8'(i));
            clr();
            end_frame();
        end
        arb_lost_in <= 1'b0;
        mst.start_cond();
        send(8'hAA, 1'b0, twu_pkg::SC_OWN_ADDR);
        wr(twu_pkg::OFF_CTRL, 8'h84);
        send(8'h5A, 1'b1, twu_pkg::SC_OWN_NACK);
        rchk(twu_pkg::OFF_DATA, 8'h5A);
        wr(twu_pkg::OFF_CTRL, 8'hE4);
        send(8'hAA, 1'b1, 8'h00);
        check(launched, 1'b0);
        mst.stop_cond();
        repeat (20) @(posedge ref_clk_in);
        check(launched, 1'b1);
        wr(twu_pkg::OFF_CTRL, 8'h04);
        mst.start_cond();
        send(8'hAA, 1'b1, 8'h00);
        mst.stop_cond();
        wr(twu_pkg::OFF_CTRL, 8'h44);
        mst.start_cond();
        send(8'hAB, 1'b0, twu_pkg::SC_ST_ADDR);
        clr();
        mst.stop_cond();
        wr(twu_pkg::OFF_ADDR, 8'hAA);
        mst.start_cond();
        send(8'h00, 1'b1, 8'h00);
        mst.stop_cond();
        wr(twu_pkg::OFF_MASK, 8'h00);
        sleep_in <= 1'b1;
        mst.start_cond();
        send(8'hAA, 1'b0, twu_pkg::SC_OWN_ADDR);
        check(wake_out, 1'b1);
        rchk(twu_pkg::OFF_IRQ, 8'h03);
        repeat (40) @(posedge ref_clk_in);
        check(scl_oe_out, 1'b1);
        check(irq_out, 1'b0);
        sleep_in <= 1'b0;
        clr();
        repeat (3) @(posedge ref_clk_in);
        check(wake_out, 1'b0);
        check(scl_oe_out, 1'b0);
        end_frame();
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge ref_clk_in);
        miscompares++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
